// ==== verilog/acr_computation.sv ====
// Converter result computation, limits and interrupt, behind a Wishbone slave
`timescale 1ns/100ps
`default_nettype none
`include "acr_consts.svh"
module acr_computation
    import acr_pkg::*;
#(
    parameter int SUM_W = 18
)
(
    // Clock and reset
    input  wire logic        sys_clk_in,
    input  wire logic        rst_n_in,
    // Wishbone slave
    input  wire logic        wb_cyc_in,
    input  wire logic        wb_stb_in,
    input  wire logic        wb_we_in,
    input  wire logic [15:0] wb_adr_in,
    input  wire logic [3:0]  wb_sel_in,
    input  wire logic [31:0] wb_dat_in,
    output logic      [31:0] wb_dat_out,
    output logic             wb_ack_out,
    // Converter core
    input  wire logic        conv_start_in,
    input  wire logic        conv_active_in,
    input  wire logic        result_valid_in,
    input  wire logic [15:0] result_in,
    // Analog control and interrupt
    output logic      [4:0]  extra_cap_pf_out,
    output logic             irq_out
);

    logic [15:0]      lth_reg, lth_next, uth_reg, uth_next, setpoint_reg, setpoint_next;
    logic [15:0]      err_reg, err_next, flt_reg, flt_next;
    logic [15:0]      prev_reg, prev_next, res_reg, res_next;
    logic [SUM_W-1:0] acc_reg, acc_next;
    logic [7:0]       cnt_reg, cnt_next, rpt_reg, rpt_next, cap_reg, cap_next;
    logic [7:0]       ctrl0_reg, ctrl0_next, ctrl1_reg, ctrl1_next;
    logic [1:0]       flags_reg, flags_next, ist_reg, ist_next, imask_reg, imask_next;
    logic             pend_reg, pend_next, chk_reg, chk_next;
    logic             ack_reg, ack_next;
    logic [31:0]      dat_reg, dat_next;
    logic [13:0]      idx;
    logic             wr, thr_evt;
    logic [7:0]       wd, rd;
    acr_mode_t        mode;
    acr_error_formula_select_t        error_formula_select;
    acr_tmd_t         limit_interrupt_mode;
    logic [2:0]       shift;
    logic [SUM_W-1:0] samp_ext, shifted;
    logic [15:0]      flt_now, err_now;
    logic             below, above, uses_rpt;

    // Decoded control fields
    assign idx      = wb_adr_in[15:2];
    assign wd       = wb_dat_in[7:0];
    assign mode     = acr_mode_t'(ctrl0_reg[`ACR_C0_MODE]);
    assign error_formula_select     = acr_error_formula_select_t'(ctrl0_reg[`ACR_C0_ERROR_FORMULA_SELECT]);
    assign limit_interrupt_mode      = acr_tmd_t'(ctrl1_reg[`ACR_C1_TMD]);
    assign shift    = ctrl1_reg[`ACR_C1_SHIFT];
    assign wr       = wb_cyc_in && wb_stb_in && wb_we_in && ack_reg && wb_sel_in[0];
    assign samp_ext = {{(SUM_W-16){result_in[15]}}, result_in};
    // Codes above the filter act as average, so only basic and accumulate skip it
    assign uses_rpt = (mode != ACR_MODE_BASIC) && (mode != ACR_MODE_ACCUM);

    // Filtered output, deviation and limit compare from current state
    always_comb
    begin
        shifted = $signed(acc_reg) >>> shift;
        flt_now = shifted[15:0];
        unique case (error_formula_select)
            ACR_ERROR_FORMULA_SELECT_RES_PREV: err_now = res_reg - prev_reg;
            ACR_ERROR_FORMULA_SELECT_RES_SETPOINT: err_now = res_reg - setpoint_reg;
            ACR_ERROR_FORMULA_SELECT_FLT_SETPOINT: err_now = flt_now - setpoint_reg;
            ACR_ERROR_FORMULA_SELECT_FLT_PREV: err_now = flt_now - prev_reg;
            default:           err_now = res_reg - setpoint_reg;
        endcase
        below = $signed(err_now) < $signed(lth_reg);
        above = $signed(err_now) > $signed(uth_reg);
        unique case (limit_interrupt_mode)
            ACR_TMD_NEVER:     thr_evt = 1'b0;
            ACR_TMD_BELOW:     thr_evt = below;
            ACR_TMD_NOT_BELOW: thr_evt = !below;
            ACR_TMD_OUTSIDE:   thr_evt = below || above;
            ACR_TMD_INSIDE:    thr_evt = !below && !above;
            ACR_TMD_NOT_ABOVE: thr_evt = !above;
            ACR_TMD_ABOVE:     thr_evt = above;
            ACR_TMD_ALWAYS:    thr_evt = 1'b1;
        endcase
    end

    // Next values of the computation state and software registers
    always_comb
    begin
        lth_next   = lth_reg;
        uth_next   = uth_reg;
        setpoint_next  = setpoint_reg;
        err_next   = err_reg;
        flt_next   = flt_reg;
        prev_next  = prev_reg;
        res_next   = res_reg;
        acc_next   = acc_reg;
        cnt_next   = cnt_reg;
        rpt_next   = rpt_reg;
        cap_next   = cap_reg;
        ctrl0_next = ctrl0_reg;
        ctrl1_next = ctrl1_reg;
        flags_next = flags_reg;
        imask_next = imask_reg;
        pend_next  = 1'b0;
        chk_next   = 1'b0;
        ist_next   = ist_reg;
        // Software writes, one byte lane per index
        if (wr)
        begin
            unique case (idx)
                `ACR_IX_LTH_L:  lth_next[7:0]   = wd;
                `ACR_IX_LTH_H:  lth_next[15:8]  = wd;
                `ACR_IX_UTH_L:  uth_next[7:0]   = wd;
                `ACR_IX_UTH_H:  uth_next[15:8]  = wd;
                `ACR_IX_SETPOINT_L: setpoint_next[7:0]  = wd;
                `ACR_IX_SETPOINT_H: setpoint_next[15:8] = wd;
                `ACR_IX_ACC_L:  if (!conv_active_in) acc_next[7:0] = wd;
                `ACR_IX_ACC_H:  if (!conv_active_in) acc_next[15:8] = wd;
                `ACR_IX_ACC_U:  if (!conv_active_in) acc_next[SUM_W-1:16] = wd[SUM_W-17:0];
                `ACR_IX_CNT:    cnt_next        = wd;
                `ACR_IX_RPT:    rpt_next        = wd;
                `ACR_IX_RES_L:  res_next[7:0]   = wd;
                `ACR_IX_RES_H:  res_next[15:8]  = wd;
                `ACR_IX_CAP:    cap_next        = {3'h0, wd[`ACR_CAP_FIELD]};
                `ACR_IX_CTRL0:  ctrl0_next      = wd;
                `ACR_IX_CTRL1:  ctrl1_next      = wd;
                `ACR_IX_IMASK:  imask_next      = wd[1:0];
                `ACR_IX_ISTAT:  ist_next        = ist_reg & ~wd[1:0];
                default:        ;
            endcase
        end
        // Snapshot at conversion start
        if (conv_start_in)
            prev_next = ctrl0_reg[`ACR_C0_SNAPSHOT_SOURCE_SELECT] ? flt_reg : res_reg;
        // New result: store, accumulate and count triggers
        if (result_valid_in)
        begin
            res_next  = result_in;
            pend_next = 1'b1;
            chk_next  = 1'b1;
            unique case (mode)
                ACR_MODE_BASIC: ;
                ACR_MODE_ACCUM: acc_next = acc_reg + samp_ext;
                ACR_MODE_LPF:   acc_next = acc_reg + samp_ext - shifted;
                default:        acc_next = (cnt_reg == `ACR_RST8) ? samp_ext
                                         : acc_reg + samp_ext;
            endcase
            if (mode != ACR_MODE_BASIC && cnt_reg != `ACR_CNT_MAX)
                cnt_next = cnt_reg + 8'h01;
            if (uses_rpt)
            begin
                // Filter mode keeps checking once the tally has reached the threshold
                chk_next = (cnt_next == rpt_reg)
                        || (mode == ACR_MODE_LPF && cnt_reg == rpt_reg);
                if (chk_next && mode != ACR_MODE_LPF)
                    cnt_next = `ACR_RST8;
                else if (chk_next)
                    cnt_next = rpt_reg;
            end
        end
        // One cycle later: filtered output, deviation and limit check
        if (pend_reg)
        begin
            if (mode != ACR_MODE_BASIC)
                flt_next = flt_now;
            err_next = err_now;
            ist_next[`ACR_IRQ_DONE] = 1'b1;
            if (chk_reg)
            begin
                flags_next[`ACR_FL_BELOW] = below;
                flags_next[`ACR_FL_ABOVE] = above;
                if (thr_evt)
                    ist_next[`ACR_IRQ_THR] = 1'b1;
            end
        end
    end

    // Byte-wide read view of every register
    always_comb
    begin
        unique case (idx)
            `ACR_IX_LTH_L:  rd = lth_reg[7:0];
            `ACR_IX_LTH_H:  rd = lth_reg[15:8];
            `ACR_IX_UTH_L:  rd = uth_reg[7:0];
            `ACR_IX_UTH_H:  rd = uth_reg[15:8];
            `ACR_IX_ERR_L:  rd = err_reg[7:0];
            `ACR_IX_ERR_H:  rd = err_reg[15:8];
            `ACR_IX_SETPOINT_L: rd = setpoint_reg[7:0];
            `ACR_IX_SETPOINT_H: rd = setpoint_reg[15:8];
            `ACR_IX_FLT_L:  rd = flt_reg[7:0];
            `ACR_IX_FLT_H:  rd = flt_reg[15:8];
            `ACR_IX_ACC_L:  rd = acc_reg[7:0];
            `ACR_IX_ACC_H:  rd = acc_reg[15:8];
            `ACR_IX_ACC_U:  rd = {{(24-SUM_W){acc_reg[SUM_W-1]}}, acc_reg[SUM_W-1:16]};
            `ACR_IX_CNT:    rd = cnt_reg;
            `ACR_IX_RPT:    rd = rpt_reg;
            `ACR_IX_PREV_L: rd = prev_reg[7:0];
            `ACR_IX_PREV_H: rd = prev_reg[15:8];
            `ACR_IX_RES_L:  rd = res_reg[7:0];
            `ACR_IX_RES_H:  rd = res_reg[15:8];
            `ACR_IX_CAP:    rd = cap_reg;
            `ACR_IX_CTRL0:  rd = ctrl0_reg;
            `ACR_IX_CTRL1:  rd = ctrl1_reg;
            `ACR_IX_FLAGS:  rd = {6'h00, flags_reg};
            `ACR_IX_ISTAT:  rd = {6'h00, ist_reg};
            `ACR_IX_IMASK:  rd = {6'h00, imask_reg};
            default:        rd = `ACR_RST8;
        endcase
    end

    // Bus handshake: ack one cycle after the request, then drop
    always_comb
    begin
        ack_next = wb_cyc_in && wb_stb_in && !ack_reg;
        dat_next = ack_next ? {24'h000000, rd} : 32'h00000000;
    end

    // Register all state
    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_n_in)
        begin
            lth_reg   <= `ACR_RST16;
            uth_reg   <= `ACR_RST16;
            setpoint_reg  <= `ACR_RST16;
            err_reg   <= `ACR_RST16;
            flt_reg   <= `ACR_RST16;
            prev_reg  <= `ACR_RST16;
            res_reg   <= `ACR_RST16;
            acc_reg   <= `ACR_RST18;
            cnt_reg   <= `ACR_RST8;
            rpt_reg   <= `ACR_RST8;
            cap_reg   <= `ACR_RST8;
            ctrl0_reg <= `ACR_RST8;
            ctrl1_reg <= `ACR_RST8;
            flags_reg <= 2'h0;
            ist_reg   <= 2'h0;
            imask_reg <= 2'h0;
            pend_reg  <= 1'b0;
            chk_reg   <= 1'b0;
            ack_reg   <= 1'b0;
            dat_reg   <= 32'h00000000;
        end
        else
        begin
            lth_reg   <= lth_next;
            uth_reg   <= uth_next;
            setpoint_reg  <= setpoint_next;
            err_reg   <= err_next;
            flt_reg   <= flt_next;
            prev_reg  <= prev_next;
            res_reg   <= res_next;
            acc_reg   <= acc_next;
            cnt_reg   <= cnt_next;
            rpt_reg   <= rpt_next;
            cap_reg   <= cap_next;
            ctrl0_reg <= ctrl0_next;
            ctrl1_reg <= ctrl1_next;
            flags_reg <= flags_next;
            ist_reg   <= ist_next;
            imask_reg <= imask_next;
            pend_reg  <= pend_next;
            chk_reg   <= chk_next;
            ack_reg   <= ack_next;
            dat_reg   <= dat_next;
        end
    end

    // Outputs
    assign wb_ack_out       = ack_reg;
    assign wb_dat_out       = dat_reg;
    assign extra_cap_pf_out = cap_reg[`ACR_CAP_FIELD];
    assign irq_out          = |(ist_reg & imask_reg);

    // Checks on the computation and bus behaviour
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);

    // Capacitance select
    cap_field_a: assert property (extra_cap_pf_out == cap_reg[4:0] && cap_reg[7:5] == 3'h0)
        else $error("extra capacitance field out of range");

    // Repeat threshold and trigger tally
    rpt_check_a: assert property (result_valid_in && uses_rpt && rpt_reg ==
        ((cnt_reg == `ACR_CNT_MAX) ? cnt_reg : cnt_reg + 8'h01) |=> chk_reg)
        else $error("threshold check missed at tally match");
    lpf_hold_a: assert property (result_valid_in && mode == ACR_MODE_LPF
        && cnt_reg == rpt_reg |=> chk_reg && cnt_reg == $past(rpt_reg))
        else $error("filter mode tally not held at threshold");
    cnt_write_a: assert property (wr && idx == `ACR_IX_CNT && !result_valid_in
        |=> cnt_reg == $past(wd))
        else $error("tally write lost");
    rpt_mode_a: assert property (result_valid_in && !uses_rpt |=> chk_reg)
        else $error("check skipped outside repeat modes");
    basic_cnt_a: assert property (result_valid_in && mode == ACR_MODE_BASIC
        && !(wr && idx == `ACR_IX_CNT) |=> $stable(cnt_reg))
        else $error("tally moved in basic mode");

    // Filtered output and snapshot
    flt_shift_a: assert property (pend_reg && mode != ACR_MODE_BASIC
        |=> flt_reg == 16'($signed($past(acc_reg)) >>> $past(shift)))
        else $error("filtered output not shifted sum");
    flt_ro_a: assert property (wr && idx == `ACR_IX_FLT_L && !pend_reg |=> $stable(flt_reg))
        else $error("filtered output changed by write");
    snap_flt_a: assert property (conv_start_in && ctrl0_reg[3] |=> prev_reg == $past(flt_reg))
        else $error("snapshot did not take filtered output");
    snap_res_a: assert property (conv_start_in && !ctrl0_reg[3] |=> prev_reg == $past(res_reg))
        else $error("snapshot did not take result");

    // Running sum
    sum_sign_a: assert property (ack_reg && idx == `ACR_IX_ACC_U && !$past(ack_reg)
        |-> wb_dat_out[7:2] == {6{$past(acc_reg[17])}})
        else $error("upper sum byte not sign extended");
    sum_lock_a: assert property (wr && conv_active_in && idx == `ACR_IX_ACC_L
        && !result_valid_in |=> $stable(acc_reg))
        else $error("sum written while converting");
    sum_write_a: assert property (wr && !conv_active_in && idx == `ACR_IX_ACC_L
        && !result_valid_in |=> acc_reg[7:0] == $past(wd))
        else $error("sum write while idle lost");

    // Deviation, limits and interrupt
    dev_error_formula_select_a: assert property (pend_reg && error_formula_select == ACR_ERROR_FORMULA_SELECT_RES_SETPOINT
        |=> err_reg == 16'($past(res_reg) - $past(setpoint_reg)))
        else $error("deviation formula wrong");
    dev_ro_a: assert property (wr && idx == `ACR_IX_ERR_L && !pend_reg
        |=> $stable(err_reg))
        else $error("deviation changed by write");
    flag_cmp_a: assert property (pend_reg && chk_reg
        |=> flags_reg[0] == ($signed($past(err_now)) < $signed($past(lth_reg)))
         && flags_reg[1] == ($signed($past(err_now)) > $signed($past(uth_reg))))
        else $error("limit flags wrong");
    flag_hold_a: assert property (!(pend_reg && chk_reg) |=> $stable(flags_reg))
        else $error("limit flags moved without a check");
    irq_gate_a: assert property (pend_reg && chk_reg && limit_interrupt_mode == ACR_TMD_NEVER
        && !ist_reg[0] |=> !ist_reg[0])
        else $error("threshold event despite never mode");
    lim_byte_a: assert property (wr && idx == `ACR_IX_LTH_H
        |=> lth_reg[15:8] == $past(wd))
        else $error("limit high byte write lost");

    // Bus handshake
    ack_pulse_a: assert property (ack_reg |=> !ack_reg)
        else $error("ack held beyond one cycle");

    cov_check_c:  cover property (pend_reg && chk_reg && thr_evt);
    cov_lpf_c:    cover property (result_valid_in && mode == ACR_MODE_LPF);
    cov_burst_c:  cover property (result_valid_in && mode == ACR_MODE_BURST);
    cov_snap_c:   cover property (conv_start_in && ctrl0_reg[3]);
    cov_irq_c:    cover property (irq_out);

endmodule
`default_nettype wire

// ==== inc/acr_consts.svh ====
// Register indices, field positions and reset values of the computation block
`ifndef ACR_CONSTS_SVH
`define ACR_CONSTS_SVH
// Register indices (byte address is four times the index)
`define ACR_IX_LTH_L    14'h1D0C
`define ACR_IX_LTH_H    14'h1D0D
`define ACR_IX_UTH_L    14'h1D0E
`define ACR_IX_UTH_H    14'h1D0F
`define ACR_IX_ERR_L    14'h1D10
`define ACR_IX_ERR_H    14'h1D11
`define ACR_IX_SETPOINT_L   14'h1D12
`define ACR_IX_SETPOINT_H   14'h1D13
`define ACR_IX_FLT_L    14'h1D14
`define ACR_IX_FLT_H    14'h1D15
`define ACR_IX_ACC_L    14'h1D16
`define ACR_IX_ACC_H    14'h1D17
`define ACR_IX_ACC_U    14'h1D18
`define ACR_IX_CNT      14'h1D19
`define ACR_IX_RPT      14'h1D1A
`define ACR_IX_PREV_L   14'h1D1B
`define ACR_IX_PREV_H   14'h1D1C
`define ACR_IX_RES_L    14'h1D1D
`define ACR_IX_RES_H    14'h1D1E
`define ACR_IX_CAP      14'h1D23
`define ACR_IX_CTRL0    14'h1D40
`define ACR_IX_CTRL1    14'h1D41
`define ACR_IX_FLAGS    14'h1D42
`define ACR_IX_ISTAT    14'h1D43
`define ACR_IX_IMASK    14'h1D44
// Field positions
`define ACR_C0_MODE     2:0
`define ACR_C0_SNAPSHOT_SOURCE_SELECT     3
`define ACR_C0_ERROR_FORMULA_SELECT     6:4
`define ACR_C1_SHIFT    2:0
`define ACR_C1_TMD      5:3
`define ACR_CAP_FIELD   4:0
`define ACR_FL_BELOW    0
`define ACR_FL_ABOVE    1
`define ACR_IRQ_THR     0
`define ACR_IRQ_DONE    1
// Reset values and tally ceiling
`define ACR_RST8        8'h00
`define ACR_RST16       16'h0000
`define ACR_RST18       18'h00000
`define ACR_CNT_MAX     8'hFF
`endif

// ==== inc/acr_pkg.sv ====
// Types shared by the computation block
package acr_pkg;
    // Computation modes in field order
    typedef enum logic [2:0] {
        ACR_MODE_BASIC,
        ACR_MODE_ACCUM,
        ACR_MODE_AVG,
        ACR_MODE_BURST,
        ACR_MODE_LPF
    } acr_mode_t;
    // Deviation formulas in field order
    typedef enum logic [2:0] {
        ACR_ERROR_FORMULA_SELECT_RES_PREV,
        ACR_ERROR_FORMULA_SELECT_RES_SETPOINT,
        ACR_ERROR_FORMULA_SELECT_FLT_SETPOINT,
        ACR_ERROR_FORMULA_SELECT_FLT_PREV
    } acr_error_formula_select_t;
    // Limit interrupt modes in field order
    typedef enum logic [2:0] {
        ACR_TMD_NEVER,
        ACR_TMD_BELOW,
        ACR_TMD_NOT_BELOW,
        ACR_TMD_OUTSIDE,
        ACR_TMD_INSIDE,
        ACR_TMD_NOT_ABOVE,
        ACR_TMD_ABOVE,
        ACR_TMD_ALWAYS
    } acr_tmd_t;
endpackage

// ==== tb/adc_computation_registers_test.sv ====
// Self-checking bench for the converter computation block over its Wishbone port
`timescale 1ns/100ps
`default_nettype none
`include "acr_consts.svh"
`define CHK(g, e) \
    begin \
        tests_run++; \
        if ((g) !== (e)) \
        begin \
            fails++; \
            $display("[ERR] %0t got %h expected %h", $time, (g), (e)); \
        end \
    end
module adc_computation_registers_test
    import acr_pkg::*;
;
    logic        sys_clk;
    logic        rst_n;
    logic        wb_cyc;
    logic        wb_stb;
    logic        wb_we;
    logic [15:0] wb_adr;
    logic [3:0]  wb_sel;
    logic [31:0] wb_wdat;
    logic [31:0] wb_rdat;
    logic        wb_ack;
    logic        conv_start;
    logic        conv_active;
    logic        result_val;
    logic [15:0] result;
    logic [4:0]  cap_pf;
    logic        irq;
    int          fails;
    int          tests_run;
    int          cycles;
    logic [7:0]  q;
    logic [15:0] smp [5] = '{16'h0100, 16'h00F0, 16'h00EF, 16'h0110, 16'h0111};
    logic [15:0] dev [5] = '{16'h0000, 16'hFFF0, 16'hFFEF, 16'h0010, 16'h0011};
    logic [7:0]  flg [5] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h02};
    // Device under test
    acr_computation uut (
        .sys_clk_in       (sys_clk),
        .rst_n_in         (rst_n),
        .wb_cyc_in        (wb_cyc),
        .wb_stb_in        (wb_stb),
        .wb_we_in         (wb_we),
        .wb_adr_in        (wb_adr),
        .wb_sel_in        (wb_sel),
        .wb_dat_in        (wb_wdat),
        .wb_dat_out       (wb_rdat),
        .wb_ack_out       (wb_ack),
        .conv_start_in    (conv_start),
        .conv_active_in   (conv_active),
        .result_valid_in  (result_val),
        .result_in        (result),
        .extra_cap_pf_out (cap_pf),
        .irq_out          (irq)
    );
    // Clock at 100 MHz
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // Print the verdict and stop
    task automatic test_done();
        if (fails == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // One classic Wishbone cycle, held until ack is sampled high
    task automatic wb_xfer(input logic w, input logic [13:0] ix, input logic [7:0] d);
        @(posedge sys_clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= w;
        wb_adr <= {ix, 2'b00};
        wb_sel <= 4'h1;
        wb_wdat <= {24'h000000, d};
        @(posedge sys_clk);
        while (wb_ack !== 1'b1) @(posedge sys_clk);
        q = wb_rdat[7:0];
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
    endtask
    task automatic wr(input logic [13:0] ix, input logic [7:0] d);
        wb_xfer(1'b1, ix, d);
    endtask
    task automatic rchk(input logic [13:0] ix, input logic [7:0] e);
        wb_xfer(1'b0, ix, 8'h00);
        `CHK(q, e)
    endtask
    // Sixteen-bit values as two byte lanes, low byte first
    task automatic wr16(input logic [13:0] ix, input logic [15:0] v);
        wr(ix, v[7:0]);
        wr(ix + 14'h0001, v[15:8]);
    endtask
    task automatic rchk16(input logic [13:0] ix, input logic [15:0] e);
        rchk(ix, e[7:0]);
        rchk(ix + 14'h0001, e[15:8]);
    endtask
    // One conversion: start, result pulse, then let the pipeline settle
    task automatic conv(input logic [15:0] s);
        @(posedge sys_clk);
        conv_start <= 1'b1;
        conv_active <= 1'b1;
        @(posedge sys_clk);
        conv_start <= 1'b0;
        repeat (2) @(posedge sys_clk);
        result_val <= 1'b1;
        result <= s;
        @(posedge sys_clk);
        result_val <= 1'b0;
        conv_active <= 1'b0;
        repeat (3) @(posedge sys_clk);
    endtask
    // Expected threshold event per interrupt mode
    function automatic logic tmd_exp(input int m, input logic b, input logic a);
        case (m)
            0: return 1'b0;
            1: return b;
            2: return !b;
            3: return b | a;
            4: return !(b | a);
            5: return !a;
            6: return a;
            default: return 1'b1;
        endcase
    endfunction
    // Hang guard
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fails++;
            test_done();
        end
    end
    // Main sequence
    initial
    begin
        {wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_wdat} = '0;
        {conv_start, conv_active, result_val, result} = '0;
        rst_n = 1'b0;
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        // Reset values and the capacitance field
        rchk16(`ACR_IX_LTH_L, 16'h0000);
        rchk16(`ACR_IX_SETPOINT_L, 16'h0000);
        rchk(`ACR_IX_CNT, 8'h00);
        rchk(`ACR_IX_RPT, 8'h00);
        rchk16(`ACR_IX_PREV_L, 16'h0000);
        `CHK(cap_pf, 5'h00)
        wr(`ACR_IX_CAP, 8'hFF);
        rchk(`ACR_IX_CAP, 8'h1F);
        `CHK(cap_pf, 5'h1F)
        wr(`ACR_IX_RPT, 8'hA5);
        rchk(`ACR_IX_RPT, 8'hA5);
        wr(`ACR_IX_CNT, 8'h05);
        rchk(`ACR_IX_CNT, 8'h05);
        // Unmapped place and read-only registers ignore writes
        wr(14'h1D50, 8'h3C);
        rchk(14'h1D50, 8'h00);
        wr(`ACR_IX_FLT_L, 8'h77);
        rchk(`ACR_IX_FLT_L, 8'h00);
        wr(`ACR_IX_ERR_L, 8'h77);
        rchk(`ACR_IX_ERR_L, 8'h00);
        // Basic mode, result minus setpoint, limit boundaries
        wr(`ACR_IX_CTRL0, 8'h10);
        wr16(`ACR_IX_SETPOINT_L, 16'h0100);
        wr16(`ACR_IX_LTH_L, 16'hFFF0);
        wr16(`ACR_IX_UTH_L, 16'h0010);
        rchk16(`ACR_IX_UTH_L, 16'h0010);
        for (int i = 0; i < 5; i++)
        begin
            conv(smp[i]);
            rchk16(`ACR_IX_RES_L, smp[i]);
            rchk16(`ACR_IX_ERR_L, dev[i]);
            rchk(`ACR_IX_FLAGS, flg[i]);
            if (i > 0)
                rchk16(`ACR_IX_PREV_L, smp[i - 1]);
        end
        // Every interrupt mode against below, inside and above
        wr(`ACR_IX_IMASK, 8'h01);
        for (int m = 0; m < 8; m++)
        begin
            wr(`ACR_IX_CTRL1, 8'(m << 3));
            for (int k = 0; k < 3; k++)
            begin
                wr(`ACR_IX_ISTAT, 8'h03);
                conv(k == 0 ? 16'h00EF : (k == 1 ? 16'h0100 : 16'h0111));
                rchk(`ACR_IX_ISTAT, {7'h01, tmd_exp(m, k == 0, k == 2)});
                `CHK(irq, tmd_exp(m, k == 0, k == 2))
            end
        end
        // Masked event stays out of the interrupt line
        wr(`ACR_IX_IMASK, 8'h00);
        conv(16'h0100);
        `CHK(irq, 1'b0)
        wr(`ACR_IX_ISTAT, 8'h03);
        rchk(`ACR_IX_ISTAT, 8'h00);
        // Accumulate mode, shift by one, negative running sum
        wr(`ACR_IX_CTRL0, 8'h11);
        wr(`ACR_IX_CTRL1, 8'h01);
        wr16(`ACR_IX_ACC_L, 16'h0000);
        wr(`ACR_IX_ACC_U, 8'h00);
        wr(`ACR_IX_CNT, 8'h00);
        conv(16'h0006);
        conv(16'h0004);
        rchk16(`ACR_IX_FLT_L, 16'h0005);
        conv(16'hFFE0);
        rchk16(`ACR_IX_FLT_L, 16'hFFF5);
        rchk16(`ACR_IX_ACC_L, 16'hFFEA);
        rchk(`ACR_IX_ACC_U, 8'hFF);
        rchk(`ACR_IX_CNT, 8'h03);
        // Sum write refused while converting
        @(posedge sys_clk);
        conv_active <= 1'b1;
        wr(`ACR_IX_ACC_L, 8'h55);
        conv_active <= 1'b0;
        rchk(`ACR_IX_ACC_L, 8'hEA);
        // Snapshot of filtered output, deviation filtered minus snapshot
        wr(`ACR_IX_CTRL0, 8'h39);
        conv(16'h0016);
        rchk16(`ACR_IX_PREV_L, 16'hFFF5);
        rchk16(`ACR_IX_ERR_L, 16'h000B);
        // Average mode with a repeat threshold of two
        wr(`ACR_IX_CTRL0, 8'h12);
        wr(`ACR_IX_CTRL1, 8'h39);
        wr(`ACR_IX_RPT, 8'h02);
        wr16(`ACR_IX_ACC_L, 16'h0000);
        wr(`ACR_IX_ACC_U, 8'h00);
        wr(`ACR_IX_CNT, 8'h00);
        wr(`ACR_IX_ISTAT, 8'h03);
        conv(16'h0004);
        rchk(`ACR_IX_CNT, 8'h01);
        rchk(`ACR_IX_ISTAT, 8'h02);
        conv(16'h0008);
        rchk16(`ACR_IX_FLT_L, 16'h0006);
        rchk(`ACR_IX_CNT, 8'h00);
        rchk(`ACR_IX_ISTAT, 8'h03);
        conv(16'h0002);
        rchk16(`ACR_IX_FLT_L, 16'h0001);
        // Low-pass filter from an empty sum
        wr(`ACR_IX_CTRL0, 8'h14);
        wr16(`ACR_IX_ACC_L, 16'h0000);
        wr(`ACR_IX_ACC_U, 8'h00);
        conv(16'h0008);
        rchk16(`ACR_IX_FLT_L, 16'h0004);
        rchk(`ACR_IX_CNT, 8'h02);
        wr(`ACR_IX_ISTAT, 8'h03);
        conv(16'h0008);
        rchk16(`ACR_IX_FLT_L, 16'h0006);
        rchk(`ACR_IX_CNT, 8'h02);
        rchk(`ACR_IX_ISTAT, 8'h03);
        // Burst average with filtered deviation, then result minus snapshot
        wr(`ACR_IX_CTRL0, 8'h23);
        wr(`ACR_IX_CNT, 8'h00);
        conv(16'h0204);
        rchk16(`ACR_IX_ERR_L, 16'h0002);
        rchk(`ACR_IX_CNT, 8'h01);
        wr(`ACR_IX_CTRL0, 8'h03);
        conv(16'h0210);
        rchk16(`ACR_IX_PREV_L, 16'h0204);
        rchk16(`ACR_IX_ERR_L, 16'h000C);
        rchk16(`ACR_IX_FLT_L, 16'h020A);
        rchk(`ACR_IX_CNT, 8'h00);
        test_done();
    end
endmodule
`default_nettype wire
